// file: tpc_defs.svh
// Register offsets, field positions, reset values and widths for the timer channel block.
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
// Register offsets on the byte-wide register port.
`define TPC_ADDR_TCTRL 4'h0
`define TPC_ADDR_CNT_HI 4'h1
`define TPC_ADDR_CNT_LO 4'h2
`define TPC_ADDR_MOD_HI 4'h3
`define TPC_ADDR_MOD_LO 4'h4
`define TPC_ADDR_CHCTRL 4'h5
`define TPC_ADDR_CHV_HI 4'h6
`define TPC_ADDR_CHV_LO 4'h7
`define TPC_ADDR_IRQ_STAT 4'h8
`define TPC_ADDR_IRQ_MASK 4'h9
// Timer control fields.
`define TPC_TCTRL_CENTER_ALIGN_SELECT 5
`define TPC_TCTRL_CLKS_HI 4
`define TPC_TCTRL_CLKS_LO 3
`define TPC_TCTRL_PS_HI 2
`define TPC_TCTRL_PS_LO 0
// Channel control and status fields.
`define TPC_CH_FLAG 7
`define TPC_CH_IE 6
`define TPC_CH_MS_HI 5
`define TPC_CH_MS_LO 4
`define TPC_CH_ELS_HI 3
`define TPC_CH_ELS_LO 2
// Interrupt status and mask bits.
`define TPC_IRQ_CH 0
`define TPC_IRQ_OVF 1
// Reset values and the top count used when the modulo is zero.
`define TPC_RST_BYTE 8'h00
`define TPC_RST_WORD 16'h0000
`define TPC_TOP_FULL 16'hFFFF
`endif

// file: tpc_pkg.sv
// Types shared by the timer channel block.
package tpc_pkg;
    typedef enum logic [2:0] {
        TPC_MODE_CAPTURE = 3'b000,
        TPC_MODE_COMPARE = 3'b001,
        TPC_MODE_EPWM = 3'b010,
        TPC_MODE_CPWM = 3'b011
    } tpc_mode_t;
endpackage

// file: tpc_timer.sv
// Timer with one capture, compare and PWM channel, byte-wide registers and interrupts.
`timescale 1ns/1ns
`include "tpc_defs.svh"
module tpc_timer
    import tpc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port.
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Channel pin.
    input wire logic ch_pin_i,
    output logic ch_pin_o,
    output logic ch_pin_oe_o,
    // Interrupts.
    output logic ch_irq_o,
    output logic irq_o
);

    // ****************************************************************
    // Registers and decode
    // ****************************************************************
    logic [15:0] mod_reg, cnt_reg, cnt_next, top, chv_reg, wbuf_reg, rbuf_reg;
    logic [7:0] tctrl_reg, rdata_reg;
    logic [6:0] pre_reg, pre_mask;
    logic [3:0] chctrl_reg;
    logic [1:0] irq_stat_reg, irq_mask_reg, els, ms;
    logic dir_up_reg, dir_up_next, tick, tof, cnt_wr, flag_reg, flag_arm_reg;
    logic whi_reg, wlo_reg, load_ok, load, rlat_reg, rfirst_hi_reg;
    logic pin_prev_reg, pin_reg, oe_reg, ch_irq_reg, irq_reg, center_align_select;
    logic match, cap_ev, ch_ev, wr_chctrl, rd_vhi, rd_vlo, wr_vhi, wr_vlo;
    tpc_mode_t mode;

    assign els = chctrl_reg[1:0];
    assign ms = chctrl_reg[3:2];
    assign center_align_select = tctrl_reg[`TPC_TCTRL_CENTER_ALIGN_SELECT];
    assign wr_chctrl = wr_i && (addr_i == `TPC_ADDR_CHCTRL);
    assign rd_vhi = rd_i && (addr_i == `TPC_ADDR_CHV_HI);
    assign rd_vlo = rd_i && (addr_i == `TPC_ADDR_CHV_LO);
    assign wr_vhi = wr_i && (addr_i == `TPC_ADDR_CHV_HI);
    assign wr_vlo = wr_i && (addr_i == `TPC_ADDR_CHV_LO);
    assign cnt_wr = wr_i && (addr_i == `TPC_ADDR_CNT_HI || addr_i == `TPC_ADDR_CNT_LO);

    // Center select overrides the per-channel mode bits.
    always_comb begin
        if (center_align_select) begin
            mode = TPC_MODE_CPWM;
        end else if (ms[1]) begin
            mode = TPC_MODE_EPWM;
        end else if (ms[0]) begin
            mode = TPC_MODE_COMPARE;
        end else begin
            mode = TPC_MODE_CAPTURE;
        end
    end

    // ****************************************************************
    // Main counter
    // ****************************************************************
    assign top = (mod_reg == `TPC_RST_WORD) ? `TPC_TOP_FULL : mod_reg;
    assign pre_mask = 7'((8'h01 << tctrl_reg[`TPC_TCTRL_PS_HI:`TPC_TCTRL_PS_LO]) - 8'h01);
    assign tick = (tctrl_reg[`TPC_TCTRL_CLKS_HI:`TPC_TCTRL_CLKS_LO] != 2'h0) && ((pre_reg & pre_mask) == pre_mask);

    always_comb begin
        cnt_next = cnt_reg;
        dir_up_next = dir_up_reg;
        tof = 1'b0;
        if (cnt_wr) begin
            cnt_next = `TPC_RST_WORD;
            dir_up_next = 1'b1;
        end else if (tick && center_align_select) begin
            if (dir_up_reg) begin
                if (cnt_reg == top) begin
                    cnt_next = cnt_reg - 16'h0001;
                    dir_up_next = 1'b0;
                    tof = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end else if (cnt_reg == `TPC_RST_WORD) begin
                cnt_next = 16'h0001;
                dir_up_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end else if (tick) begin
            dir_up_next = 1'b1;
            if (cnt_reg == top) begin
                cnt_next = `TPC_RST_WORD;
                tof = 1'b1;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_reg <= `TPC_RST_WORD;
            dir_up_reg <= 1'b1;
            pre_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_next;
            dir_up_reg <= dir_up_next;
            pre_reg <= (cnt_wr || tctrl_reg[`TPC_TCTRL_CLKS_HI:`TPC_TCTRL_CLKS_LO] == 2'h0) ? 7'h00 : pre_reg + 7'h01;
        end
    end

    // Match is taken against the next count so the action lands with the new value.
    assign match = tick && !cnt_wr && (cnt_next == chv_reg);

    // ****************************************************************
    // Channel events and flag
    // ****************************************************************
    assign cap_ev = (mode == TPC_MODE_CAPTURE) && ((els[0] && ch_pin_i && !pin_prev_reg) ||
        (els[1] && !ch_pin_i && pin_prev_reg));
    assign ch_ev = cap_ev || (match && mode != TPC_MODE_CAPTURE);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= ch_pin_i;
        end
    end

    // A new event wins over the clear and restarts the clearing sequence.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            flag_reg <= 1'b0;
            flag_arm_reg <= 1'b0;
        end else if (ch_ev) begin
            flag_reg <= 1'b1;
            flag_arm_reg <= 1'b0;
        end else if (wr_chctrl && flag_arm_reg && !wdata_i[`TPC_CH_FLAG]) begin
            flag_reg <= 1'b0;
            flag_arm_reg <= 1'b0;
        end else if (rd_i && addr_i == `TPC_ADDR_CHCTRL && flag_reg) begin
            flag_arm_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // Channel value and byte coherency
    // ****************************************************************
    assign load_ok = (mode == TPC_MODE_COMPARE) || (mode == TPC_MODE_EPWM && tick && cnt_next == `TPC_RST_WORD) ||
        (mode == TPC_MODE_CPWM && tof);
    assign load = whi_reg && wlo_reg && load_ok && mode != TPC_MODE_CAPTURE;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            chv_reg <= `TPC_RST_WORD;
        end else if (cap_ev) begin
            chv_reg <= cnt_reg;
        end else if (mode == TPC_MODE_CAPTURE && wr_vhi) begin
            chv_reg[15:8] <= wdata_i;
        end else if (mode == TPC_MODE_CAPTURE && wr_vlo) begin
            chv_reg[7:0] <= wdata_i;
        end else if (load) begin
            chv_reg <= wbuf_reg;
        end
    end

    // Write pairing: either order, cancelled by a control write.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wbuf_reg <= `TPC_RST_WORD;
            whi_reg <= 1'b0;
            wlo_reg <= 1'b0;
        end else if (wr_chctrl || mode == TPC_MODE_CAPTURE) begin
            whi_reg <= 1'b0;
            wlo_reg <= 1'b0;
        end else if (wr_vhi) begin
            wbuf_reg[15:8] <= wdata_i;
            whi_reg <= 1'b1;
            wlo_reg <= wlo_reg && !load;
        end else if (wr_vlo) begin
            wbuf_reg[7:0] <= wdata_i;
            wlo_reg <= 1'b1;
            whi_reg <= whi_reg && !load;
        end else if (load) begin
            whi_reg <= 1'b0;
            wlo_reg <= 1'b0;
        end
    end

    // Read latch: the first byte read freezes both, the other byte releases.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rbuf_reg <= `TPC_RST_WORD;
            rlat_reg <= 1'b0;
            rfirst_hi_reg <= 1'b0;
        end else if (wr_chctrl) begin
            rlat_reg <= 1'b0;
        end else if (mode == TPC_MODE_CAPTURE && (rd_vhi || rd_vlo)) begin
            if (!rlat_reg) begin
                rbuf_reg <= chv_reg;
                rlat_reg <= 1'b1;
                rfirst_hi_reg <= rd_vhi;
            end else if (rd_vhi != rfirst_hi_reg) begin
                rlat_reg <= 1'b0;
            end
        end
    end


    // ****************************************************************
    // Pin output
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pin_reg <= 1'b0;
        end else begin
            case (mode)
                TPC_MODE_COMPARE: begin
                    if (match && els == 2'h1) begin
                        pin_reg <= !pin_reg;
                    end else if (match && els[1]) begin
                        pin_reg <= els[0];
                    end
                end
                TPC_MODE_EPWM: begin
                    // Match wins over the wrap so a zero value gives zero duty.
                    if (match) begin
                        pin_reg <= els[0];
                    end else if (tof) begin
                        pin_reg <= !els[0];
                    end
                end
                TPC_MODE_CPWM: begin
                    if (match) begin
                        pin_reg <= dir_up_next ? els[0] : !els[0];
                    end
                end
                default: begin
                    pin_reg <= pin_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= (els != 2'h0) && (mode != TPC_MODE_CAPTURE);
        end
    end

    // ****************************************************************
    // Register writes and interrupts
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tctrl_reg <= `TPC_RST_BYTE;
            mod_reg <= `TPC_RST_WORD;
            chctrl_reg <= 4'h0;
            irq_mask_reg <= 2'h0;
        end else if (wr_i) begin
            case (addr_i)
                `TPC_ADDR_TCTRL: tctrl_reg <= {2'h0, wdata_i[5:0]};
                `TPC_ADDR_MOD_HI: mod_reg[15:8] <= wdata_i;
                `TPC_ADDR_MOD_LO: mod_reg[7:0] <= wdata_i;
                `TPC_ADDR_CHCTRL: chctrl_reg <= {wdata_i[`TPC_CH_MS_HI:`TPC_CH_MS_LO],
                    wdata_i[`TPC_CH_ELS_HI:`TPC_CH_ELS_LO]};
                `TPC_ADDR_IRQ_MASK: irq_mask_reg <= wdata_i[1:0];
                default: irq_mask_reg <= irq_mask_reg;
            endcase
        end
    end

    logic ie_reg;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ie_reg <= 1'b0;
        end else if (wr_chctrl) begin
            ie_reg <= wdata_i[`TPC_CH_IE];
        end
    end

    // Sticky status; a new event wins over a write-one clear.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_stat_reg <= 2'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~((wr_i && addr_i == `TPC_ADDR_IRQ_STAT) ? wdata_i[1:0] : 2'h0)) |
                {tof, ch_ev};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ch_irq_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            ch_irq_reg <= flag_reg && ie_reg;
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_reg <= `TPC_RST_BYTE;
        end else if (rd_i) begin
            case (addr_i)
                `TPC_ADDR_TCTRL: rdata_reg <= tctrl_reg;
                `TPC_ADDR_CNT_HI: rdata_reg <= cnt_reg[15:8];
                `TPC_ADDR_CNT_LO: rdata_reg <= cnt_reg[7:0];
                `TPC_ADDR_MOD_HI: rdata_reg <= mod_reg[15:8];
                `TPC_ADDR_MOD_LO: rdata_reg <= mod_reg[7:0];
                `TPC_ADDR_CHCTRL: rdata_reg <= {flag_reg, ie_reg, chctrl_reg, 2'h0};
                `TPC_ADDR_CHV_HI: rdata_reg <= rlat_reg ? rbuf_reg[15:8] : chv_reg[15:8];
                `TPC_ADDR_CHV_LO: rdata_reg <= rlat_reg ? rbuf_reg[7:0] : chv_reg[7:0];
                `TPC_ADDR_IRQ_STAT: rdata_reg <= {6'h00, irq_stat_reg};
                `TPC_ADDR_IRQ_MASK: rdata_reg <= {6'h00, irq_mask_reg};
                default: rdata_reg <= `TPC_RST_BYTE;
            endcase
        end
    end

    assign rdata_o = rdata_reg;
    assign ch_pin_o = pin_reg;
    assign ch_pin_oe_o = oe_reg;
    assign ch_irq_o = ch_irq_reg;
    assign irq_o = irq_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence flag_armed_s;
        rd_i && addr_i == `TPC_ADDR_CHCTRL && flag_reg && !ch_ev;
    endsequence

    sequence clear_write_s;
        wr_chctrl && !wdata_i[`TPC_CH_FLAG] && !ch_ev;
    endsequence

    pin_release_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        els == 2'h0 |=> !ch_pin_oe_o) else $error("pin driven with edge/level zero");
    capture_rise_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mode == TPC_MODE_CAPTURE && els == 2'h1 && ch_pin_i && !pin_prev_reg |=> chv_reg == $past(cnt_reg))
        else $error("rising capture missed");
    toggle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mode == TPC_MODE_COMPARE && els == 2'h1 && match |=> ch_pin_o != $past(ch_pin_o))
        else $error("compare toggle missed");
    epwm_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mode == TPC_MODE_EPWM && els == 2'h2 && match |=> !ch_pin_o) else $error("edge pwm not cleared");
    cpwm_up_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        center_align_select && els == 2'h2 && match && dir_up_next |=> !ch_pin_o) else $error("center pwm not cleared");
    ctrl_release_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_chctrl |=> !rlat_reg && !whi_reg && !wlo_reg) else $error("control write kept latches");
    pair_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mode == TPC_MODE_COMPARE && !center_align_select && whi_reg && wlo_reg && !cap_ev |=> chv_reg == $past(wbuf_reg))
        else $error("paired write not loaded");
    flag_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ch_ev |=> flag_reg ##1 (ch_irq_o == $past(ie_reg))) else $error("flag not set on event");
    flag_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        flag_armed_s ##1 clear_write_s |=> !flag_reg) else $error("flag clear sequence failed");
    updown_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        center_align_select && tick && !cnt_wr && dir_up_reg && cnt_reg == top |=> !dir_up_reg) else $error("no turn at top");

endmodule

// file: tpc_pin_model.sv
// Behavioural source of the external signal on the timer channel pin.
`timescale 1ns/1ns
// ****************************************
// Pin source
// ****************************************
module tpc_pin_model (
    // Level asked for by the bench.
    input wire logic level_i,
    // Device side of the pin.
    input wire logic dev_pin_i,
    input wire logic dev_oe_i,
    // Resolved pin wire.
    output logic pin_o
);
    // The outside source yields while the device drives, so the wire never fights.
    assign pin_o = dev_oe_i ? dev_pin_i : level_i;
endmodule

// file: timer_channel_capture_compare_pwm_bench.sv
// Self-checking bench for the timer channel block.
`timescale 1ns/1ns
`include "tpc_defs.svh"
// ****************************************
// Bench
// ****************************************
module timer_channel_capture_compare_pwm_bench;
    typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] q;} tpc_row_t;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic pin_ext = 1'b0;
    logic [7:0] rdata_o;
    logic ch_pin_i, ch_pin_o, ch_pin_oe_o, ch_irq_o, irq_o;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    // Unmapped writes must read back as zero.
    tpc_row_t rows [5] = '{'{`TPC_ADDR_MOD_HI, 8'h12, 8'h12}, '{`TPC_ADDR_MOD_LO, 8'h34, 8'h34},
        '{`TPC_ADDR_IRQ_MASK, 8'h01, 8'h01}, '{`TPC_ADDR_CHCTRL, 8'h4C, 8'h4C}, '{4'hF, 8'hFF, 8'h00}};
    // Edge/level in bits 2:1, expected pin after the match in bit 0.
    logic [2:0] cmp [6] = '{3'b000, 3'b111, 3'b010, 3'b100, 3'b011, 3'b100};

    tpc_timer DUT (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .ch_pin_i(ch_pin_i), .ch_pin_o(ch_pin_o),
        .ch_pin_oe_o(ch_pin_oe_o), .ch_irq_o(ch_irq_o), .irq_o(irq_o));
    tpc_pin_model PIN (.level_i(pin_ext), .dev_pin_i(ch_pin_o), .dev_oe_i(ch_pin_oe_o), .pin_o(ch_pin_i));

    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // The flag only clears after a read of the control byte, so both go together.
    task automatic clr(input logic [7:0] c);
        @(posedge clk_i);
        addr_i <= `TPC_ADDR_CHCTRL;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        wdata_i <= c;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic edge_at(input logic v, output int c);
        @(posedge clk_i);
        pin_ext <= v;
        c = cyc;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        // A flag just cleared still shows on the interrupt output until the next edge.
        repeat (2) @(posedge clk_i);
        while (ch_irq_o !== 1'b1) begin
            @(posedge clk_i);
            n++;
            if (n > 400) begin
                num_errors++;
                $display("unexpected ch_irq_o expected 1 seen 0");
                wrap_up();
            end
        end
    endtask
    task automatic hi_cnt(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(posedge clk_i);
            h += (ch_pin_o === 1'b1);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] h, l, q;
        logic [15:0] v1, v2, v3;
        int c1, c2, c3, n1, n2;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a, q);
            check("reset value", 16'(q), 16'h0000);
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, q);
            check("read back", 16'(q), 16'(rows[i].q));
        end
        rd(`TPC_ADDR_CHV_HI, h);
        rd(`TPC_ADDR_CHV_LO, l);
        check("value reset", {h, l}, 16'h0000);
        $display("register test done");
        wr(`TPC_ADDR_TCTRL, 8'h08);
        for (int e = 1; e < 4; e++) begin
            clr(8'h40 | 8'(e << 2));
            edge_at(1'b1, c1);
            check("rise flag", 16'(ch_irq_o), 16'(e & 1));
            clr(8'h40 | 8'(e << 2));
            edge_at(1'b0, c1);
            check("fall flag", 16'(ch_irq_o), 16'(e >> 1));
            clr(8'h40 | 8'(e << 2));
        end
        wr(`TPC_ADDR_CNT_LO, 8'h00);
        clr(8'h4C);
        edge_at(1'b1, c1);
        rd(`TPC_ADDR_CHV_HI, h);
        edge_at(1'b0, c2);
        rd(`TPC_ADDR_CHV_LO, l);
        v1 = {h, l};
        rd(`TPC_ADDR_CHV_HI, h);
        rd(`TPC_ADDR_CHV_LO, l);
        v2 = {h, l};
        check("capture gap", v2 - v1, 16'(c2 - c1));
        rd(`TPC_ADDR_CHV_HI, h);
        edge_at(1'b1, c3);
        wr(`TPC_ADDR_CHCTRL, 8'h4C);
        rd(`TPC_ADDR_CHV_HI, h);
        rd(`TPC_ADDR_CHV_LO, l);
        v3 = {h, l};
        check("latch release", v3 - v2, 16'(c3 - c2));
        $display("capture test done");
        clr(8'h50);
        wr(`TPC_ADDR_CHV_HI, 8'h00);
        wr(`TPC_ADDR_CHV_LO, 8'h20);
        foreach (cmp[i]) begin
            // Zero the counter first so no match slips in before the flag is cleared.
            wr(`TPC_ADDR_CNT_LO, 8'h00);
            wr(`TPC_ADDR_IRQ_STAT, 8'h01);
            clr(8'h50 | 8'({cmp[i][2:1], 2'h0}));
            wait_irq();
            check("oe", 16'(ch_pin_oe_o), 16'(cmp[i][2:1] != 2'b00));
            if (cmp[i][2:1] != 2'b00) check("pin", 16'(ch_pin_o), 16'(cmp[i][0]));
            check("irq", 16'(irq_o), 16'h0001);
        end
        wr(`TPC_ADDR_CHCTRL, 8'hD8);
        wr(`TPC_ADDR_CHCTRL, 8'h58);
        repeat (2) @(posedge clk_i);
        check("flag kept", 16'(ch_irq_o), 16'h0001);
        clr(8'h58);
        repeat (2) @(posedge clk_i);
        check("flag cleared", 16'(ch_irq_o), 16'h0000);
        wr(`TPC_ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clk_i);
        check("masked irq", 16'(irq_o), 16'h0000);
        wr(`TPC_ADDR_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk_i);
        check("unmasked irq", 16'(irq_o), 16'h0001);
        wr(`TPC_ADDR_IRQ_STAT, 8'h01);
        repeat (2) @(posedge clk_i);
        check("cleared irq", 16'(irq_o), 16'h0000);
        $display("compare test done");
        wr(`TPC_ADDR_CHV_HI, 8'h55);
        rd(`TPC_ADDR_CHV_HI, h);
        check("half write", 16'(h), 16'h0000);
        wr(`TPC_ADDR_CHV_LO, 8'h05);
        rd(`TPC_ADDR_CHV_HI, h);
        rd(`TPC_ADDR_CHV_LO, l);
        check("pair write", {h, l}, 16'h5505);
        wr(`TPC_ADDR_CHV_HI, 8'h00);
        wr(`TPC_ADDR_CHCTRL, 8'h58);
        wr(`TPC_ADDR_CHV_LO, 8'h06);
        rd(`TPC_ADDR_CHV_HI, h);
        rd(`TPC_ADDR_CHV_LO, l);
        check("dropped pair", {h, l}, 16'h5505);
        wr(`TPC_ADDR_CHV_HI, 8'h00);
        $display("buffer test done");
        wr(`TPC_ADDR_MOD_HI, 8'h00);
        wr(`TPC_ADDR_MOD_LO, 8'h0F);
        wr(`TPC_ADDR_CNT_LO, 8'h00);
        wr(`TPC_ADDR_CHCTRL, 8'h28);
        repeat (40) @(posedge clk_i);
        hi_cnt(16, n1);
        check("edge high-true", 16'(n1), 16'h0006);
        wr(`TPC_ADDR_CHCTRL, 8'h24);
        repeat (40) @(posedge clk_i);
        hi_cnt(16, n1);
        check("edge low-true", 16'(n1), 16'h000A);
        wr(`TPC_ADDR_TCTRL, 8'h09);
        wr(`TPC_ADDR_CNT_LO, 8'h00);
        repeat (40) @(posedge clk_i);
        hi_cnt(32, n1);
        check("prescaled low-true", 16'(n1), 16'h0014);
        wr(`TPC_ADDR_TCTRL, 8'h28);
        wr(`TPC_ADDR_CNT_LO, 8'h00);
        wr(`TPC_ADDR_CHCTRL, 8'h08);
        repeat (40) @(posedge clk_i);
        hi_cnt(30, n1);
        check("center drive", 16'(n1), 16'h000C);
        wr(`TPC_ADDR_CHCTRL, 8'h04);
        repeat (40) @(posedge clk_i);
        hi_cnt(30, n2);
        check("center period", 16'(n1 + n2), 16'h001E);
        rd(`TPC_ADDR_IRQ_STAT, q);
        check("overflow status", 16'(q), 16'h0003);
        $display("pwm test done");
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(`TPC_ADDR_CHV_LO, l);
        check("value after reset", 16'(l), 16'h0000);
        check("oe after reset", 16'(ch_pin_oe_o), 16'h0000);
        $display("reset test done");
        wrap_up();
    end
endmodule
